//--- rtl/adc_core_calibration_sequencer.v
// The APB interface to the registers is this design's own decision.
`timescale 1ns/1ps
`include "cal_seq_defines.vh"
module adc_core_calibration_sequencer
(
    input wire mclk,
    input wire arst_n,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output wire pready,
    output wire pslverr,
    input wire calibration_trigger_pin,
    input wire sampleStrobe,
    input wire [35:0] coreSamples,
    output reg [35:0] sampleOut,
    output reg [5:0] coreOnline,
    output reg [5:0] coreCalibrating,
    output reg stimulusSelect,
    output reg offsetCalActive,
    output reg fgDone,
    output reg [7:0] swapSourceDelay,
    output reg [7:0] swapSelectDelay
);
    // ----------------------------------------
    // State encodings
    // ----------------------------------------
    localparam [4:0] ST_IDLE = 5'b00001;
    localparam [4:0] ST_FG = 5'b00010;
    localparam [4:0] ST_FGOFS = 5'b00100;
    localparam [4:0] ST_BGCAL = 5'b01000;
    localparam [4:0] ST_SWAP = 5'b10000;
    localparam [15:0] CAL_LOAD = `CAL_CYCLES;
    localparam [15:0] OFS_LOAD = `OFS_CAL_CYCLES;

    // ----------------------------------------
    // Registers and wires
    // ----------------------------------------
    reg [31:0] ctrl_q;
    reg [4:0] trimSel_q;
    reg [4:0] state_q;
    reg [4:0] state_d;
    reg pinMeta_q;
    reg pinSync_q;
    reg pinPrev_q;
    reg softPrev_q;
    reg powerUp_q;
    reg [2:0] slot_q;
    reg [2:0] spareIdx_q;
    reg [2:0] victim_q;
    reg bgDone_q;
    reg startTimer;
    reg [15:0] timerLoad;
    wire timerDone;
    wire timerBusy;
    wire [7:0] trimRd;
    wire wrStb;
    wire rdStb;
    wire trigSel;
    wire trigger;
    wire [1:0] variant;
    wire trimWr;
    wire [2:0] pairA;
    wire [2:0] pairB;
    wire [2:0] spare;
    wire [2:0] nextVictim;

    assign wrStb = psel && penable && pwrite;
    assign rdStb = psel && penable && !pwrite;
    assign pready = 1'b1;
    assign pslverr = 1'b0;
    assign variant = ctrl_q[`CTRL_VAR_HI:`CTRL_VAR_LO];
    assign trimWr = wrStb && paddr == `OFS_TRIM_DATA;

    // ----------------------------------------
    // Submodules
    // ----------------------------------------
    trim_store u_trim
    (
        .mclk(mclk),
        .arst_n(arst_n),
        .wrEn(trimWr),
        .addr(trimSel_q),
        .wrData(pwdata[7:0]),
        .rdData(trimRd)
    );

    cal_timer u_timer
    (
        .mclk(mclk),
        .arst_n(arst_n),
        .start(startTimer),
        .load(timerLoad),
        .done(timerDone),
        .busy(timerBusy)
    );

    // ----------------------------------------
    // APB register writes
    // ----------------------------------------
    always @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            ctrl_q <= `CTRL_RST;
            trimSel_q <= 5'h00;
            swapSourceDelay <= `DLY_RST;
            swapSelectDelay <= `DLY_RST;
        end
        else if (wrStb)
        begin
            case (paddr)
                `OFS_CTRL: ctrl_q <= {25'h0, pwdata[6:0]};
                `OFS_TRIM_SEL: trimSel_q <= pwdata[4:0];
                `OFS_SRC_DLY: swapSourceDelay <= pwdata[7:0];
                `OFS_SEL_DLY: swapSelectDelay <= pwdata[7:0];
                default: ;
            endcase
        end
    end

    // ----------------------------------------
    // APB read mux
    // ----------------------------------------
    always @*
    begin
        prdata = 32'h00000000;
        if (rdStb)
        begin
            case (paddr)
                `OFS_CTRL: prdata = ctrl_q;
                `OFS_STATUS: prdata = {21'h0, bgDone_q, spareIdx_q, state_q, fgDone, 1'b0};
                `OFS_TRIM_SEL: prdata = {27'h0, trimSel_q};
                `OFS_TRIM_DATA: prdata = {24'h0, trimRd};
                `OFS_SRC_DLY: prdata = {24'h0, swapSourceDelay};
                `OFS_SEL_DLY: prdata = {24'h0, swapSelectDelay};
                default: prdata = 32'h00000000;
            endcase
        end
    end

    // ----------------------------------------
    // Trigger pin synchroniser and edge detect
    // ----------------------------------------
    always @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            pinMeta_q <= 1'b0;
            pinSync_q <= 1'b0;
            pinPrev_q <= 1'b0;
            softPrev_q <= 1'b0;
        end
        else
        begin
            pinMeta_q <= calibration_trigger_pin;
            pinSync_q <= pinMeta_q;
            pinPrev_q <= pinSync_q;
            softPrev_q <= ctrl_q[`CTRL_SOFT_TRIG];
        end
    end

    // Source select: 1 picks the pin, 0 the software bit
    assign trigSel = ctrl_q[`CTRL_TRIG_SEL];
    assign trigger = trigSel ? (pinSync_q && !pinPrev_q) :
        (ctrl_q[`CTRL_SOFT_TRIG] && !softPrev_q);

    // ----------------------------------------
    // Spare rotation table
    // ----------------------------------------
    // Quad uses two spares, dual and single one
    assign pairA = 3'd0;
    assign pairB = (variant == `VAR_SINGLE) ? 3'd0 : 3'd1;
    assign spare = (slot_q[1] && variant == `VAR_QUAD) ? 3'd3 : 3'd2;
    assign nextVictim = (variant != `VAR_QUAD) ? (slot_q[0] ? pairB : pairA) :
        (slot_q == 3'd0) ? pairA :
        (slot_q == 3'd1) ? pairB :
        (slot_q == 3'd2) ? 3'd4 : 3'd5;

    // ----------------------------------------
    // Sequencer next state
    // ----------------------------------------
    always @*
    begin
        state_d = state_q;
        startTimer = 1'b0;
        timerLoad = CAL_LOAD;
        case (state_q)
            ST_IDLE:
            begin
                if (powerUp_q || (trigger && !ctrl_q[`CTRL_BG]))
                begin
                    state_d = ST_FG;
                    startTimer = 1'b1;
                end
                else if (ctrl_q[`CTRL_BG] && !trigSel && ctrl_q[`CTRL_SOFT_TRIG])
                begin
                    state_d = ST_BGCAL;
                    startTimer = 1'b1;
                end
            end
            ST_FG:
            begin
                if (timerDone)
                begin
                    if (ctrl_q[`CTRL_FG_OFS])
                    begin
                        state_d = ST_FGOFS;
                        startTimer = 1'b1;
                        timerLoad = OFS_LOAD;
                    end
                    else
                        state_d = ST_IDLE;
                end
            end
            ST_FGOFS:
            begin
                if (timerDone)
                    state_d = ST_IDLE;
            end
            ST_BGCAL:
            begin
                if (timerDone)
                    state_d = ST_SWAP;
                else if (!ctrl_q[`CTRL_BG])
                    state_d = ST_IDLE;
            end
            ST_SWAP:
            begin
                if (sampleStrobe)
                begin
                    state_d = ctrl_q[`CTRL_BG] ? ST_BGCAL : ST_IDLE;
                    startTimer = ctrl_q[`CTRL_BG];
                end
            end
            default: state_d = ST_IDLE;
        endcase
    end

    // ----------------------------------------
    // Sequencer state and rotation bookkeeping
    // ----------------------------------------
    always @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            state_q <= ST_IDLE;
            powerUp_q <= 1'b1;
            fgDone <= 1'b0;
            slot_q <= 3'd0;
            spareIdx_q <= 3'd2;
            victim_q <= 3'd0;
            bgDone_q <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            powerUp_q <= 1'b0;
            if (state_q == ST_IDLE && state_d == ST_FG)
                fgDone <= 1'b0;
            else if ((state_q == ST_FG || state_q == ST_FGOFS) && state_d == ST_IDLE)
                fgDone <= 1'b1;
            if (state_q == ST_SWAP && sampleStrobe)
            begin
                // Calibrated spare takes over; freed core becomes the next spare
                spareIdx_q <= victim_q;
                bgDone_q <= 1'b1;
                if (variant == `VAR_QUAD)
                    slot_q <= (slot_q == 3'd3) ? 3'd0 : slot_q + 3'd1;
                else
                    slot_q <= {2'b00, ~slot_q[0]};
            end
            if (state_q != ST_BGCAL && state_d == ST_BGCAL)
                victim_q <= nextVictim;
        end
    end

    // ----------------------------------------
    // Core roles and output sample path
    // ----------------------------------------
    always @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            coreOnline <= 6'h00;
            coreCalibrating <= 6'h00;
            stimulusSelect <= 1'b0;
            offsetCalActive <= 1'b0;
            sampleOut <= 36'h000000000;
        end
        else
        begin
            stimulusSelect <= state_d != ST_IDLE;
            offsetCalActive <= state_q == ST_FGOFS ||
                (state_q == ST_BGCAL && ctrl_q[`CTRL_BG_OFS]);
            // Roles follow the next state into foreground so outputs and fgDone move together on entry
            if (state_d == ST_FG || state_d == ST_FGOFS)
            begin
                coreOnline <= 6'h00;
                coreCalibrating <= 6'h3f;
                sampleOut <= {4{`MID_CODE}};
            end
            else if (sampleStrobe)
            begin
                // Foreground map: A=0, B=1, C=4, D=5
                coreOnline <= 6'h33;
                coreCalibrating <= 6'h00;
                sampleOut <= {coreSamples[45-10 -: 9], coreSamples[36-10 -: 9],
                    coreSamples[17:9], coreSamples[8:0]};
                if (state_q == ST_BGCAL)
                begin
                    // Spare stands in for the core under calibration
                    coreOnline <= (6'h33 | (6'h01 << spare)) & ~(6'h01 << nextVictim);
                    coreCalibrating <= 6'h01 << nextVictim;
                    case (nextVictim)
                        3'd0: sampleOut[8:0] <= coreSamples[spare*9 +: 9];
                        3'd1: sampleOut[17:9] <= coreSamples[spare*9 +: 9];
                        3'd4: sampleOut[26:18] <= coreSamples[spare*9 +: 9];
                        default: sampleOut[35:27] <= coreSamples[spare*9 +: 9];
                    endcase
                end
            end
            // No core stays under calibration once the sequencer idles
            if (state_d == ST_IDLE)
                coreCalibrating <= 6'h00;
        end
    end
endmodule // adc_core_calibration_sequencer

//--- rtl/cal_seq_defines.vh
`ifndef CAL_SEQ_DEFINES_VH
`define CAL_SEQ_DEFINES_VH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define OFS_CTRL 12'h010
`define OFS_STATUS 12'h014
`define OFS_TRIM_SEL 12'h018
`define OFS_TRIM_DATA 12'h01c
// Swap delays keep their unaligned index; byte address is four times it
`define IDX_SRC_DLY 12'h09a
`define IDX_SEL_DLY 12'h09b
`define OFS_SRC_DLY (`IDX_SRC_DLY << 2)
`define OFS_SEL_DLY (`IDX_SEL_DLY << 2)
`define OFS_MASK 12'hffc

// ----------------------------------------
// Control fields
// ----------------------------------------
`define CTRL_BG 0
`define CTRL_TRIG_SEL 1
`define CTRL_SOFT_TRIG 2
`define CTRL_FG_OFS 3
`define CTRL_BG_OFS 4
`define CTRL_VAR_LO 5
`define CTRL_VAR_HI 6

// Variants
`define VAR_QUAD 2'h0
`define VAR_DUAL 2'h1
`define VAR_SINGLE 2'h2

// ----------------------------------------
// Reset values and timing
// ----------------------------------------
`define CTRL_RST 32'h00000000
`define DLY_RST 8'h00
`define MID_CODE 9'h000
`define NUM_CORES 6
`define NUM_TRIMS 18
`define CAL_TIME_NS 2000
`define CLK_NS 20
`define CAL_CYCLES 16'd100
`define OFS_CAL_CYCLES 16'd16

`endif

//--- rtl/trim_store.v
`timescale 1ns/1ps
// ----------------------------------------
// Trim memory: 18 words, factory values at reset
// ----------------------------------------
module trim_store
(
    input wire mclk,
    input wire arst_n,
    input wire wrEn,
    input wire [4:0] addr,
    input wire [7:0] wrData,
    output reg [7:0] rdData
);
    reg [7:0] mem [0:17];
    genvar i;

    // Each entry resets to its factory value and takes writes
    generate
        for (i = 0; i < 18; i = i + 1)
        begin : g_word
            always @(posedge mclk or negedge arst_n)
            begin
                if (!arst_n)
                    mem[i] <= 8'h80;
                else if (wrEn && addr == i)
                    mem[i] <= wrData;
            end
        end
    endgenerate

    // Registered read port
    always @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
            rdData <= 8'h00;
        else if (addr < 5'd18)
            rdData <= mem[addr];
        else
            rdData <= 8'h00;
    end
endmodule // trim_store

//--- rtl/cal_timer.v
`timescale 1ns/1ps
// ----------------------------------------
// Down counter that pulses done when expired
// ----------------------------------------
module cal_timer
(
    input wire mclk,
    input wire arst_n,
    input wire start,
    input wire [15:0] load,
    output reg done,
    output wire busy
);
    reg [15:0] cnt_q;

    assign busy = (cnt_q != 16'h0000);

    // Load on start, count to zero, pulse done
    always @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            cnt_q <= 16'h0000;
            done <= 1'b0;
        end
        else
        begin
            done <= (cnt_q == 16'h0001);
            if (start)
                cnt_q <= load;
            else if (busy)
                cnt_q <= cnt_q - 16'h0001;
        end
    end
endmodule // cal_timer

//--- tb/core_feed.sv
`timescale 1ns/1ps
// --------------------------------
// Converter core sample source
// --------------------------------
module core_feed
(
    input wire mclk,
    input wire arst_n,
    output logic sampleStrobe,
    output logic [35:0] coreSamples
);
    logic [1:0] div_q;
    logic [8:0] ramp_q;
    // Sample boundary every fourth clock, ramp moves each sample
    always @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
            {div_q, ramp_q} <= {2'h0, 9'h040};
        else
        begin
            div_q <= div_q + 2'h1;
            if (div_q == 2'h3)
                ramp_q <= ramp_q + 9'h011;
        end
    end
    // Four lanes, each a different non-DC pattern
    assign sampleStrobe = (div_q == 2'h3);
    assign coreSamples = {ramp_q ^ 9'h1aa, ramp_q ^ 9'h155, ~ramp_q, ramp_q};
endmodule // core_feed

//--- tb/cal_seq_chk.sv
`timescale 1ns/1ps
// --------------------------------
// Port checker
// --------------------------------
module cal_seq_chk
(
    input wire mclk,
    input wire arst_n,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    input wire pready,
    input wire pslverr,
    input wire sampleStrobe,
    input wire [35:0] sampleOut,
    input wire [5:0] coreOnline,
    input wire [5:0] coreCalibrating,
    input wire stimulusSelect,
    input wire fgDone,
    input wire [7:0] swapSourceDelay,
    input wire [7:0] swapSelectDelay
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!arst_n);
    logic [7:0] busy_q;
    // Saturating count of cycles with foreground busy
    always @(posedge mclk or negedge arst_n)
        if (!arst_n)
            busy_q <= 8'h00;
        else
            busy_q <= fgDone ? 8'h00 : busy_q + {7'h00, busy_q != 8'hff};
    sequence srcWr;
        psel && penable && pwrite && paddr == 12'h268;
    endsequence
    sequence selWr;
        psel && penable && pwrite && paddr == 12'h26c;
    endsequence
    chk_zero_wait: assert property (pready && !pslverr)
        else $error("apb answer not immediate");
    chk_fg_midcode: assert property (!fgDone |-> sampleOut == 36'h0)
        else $error("output not mid-code in foreground");
    chk_fg_bound: assert property (busy_q < 8'd160)
        else $error("foreground calibration too long");
    chk_one_core: assert property (fgDone |-> $onehot0(coreCalibrating))
        else $error("more than one core calibrating");
    chk_cal_offline: assert property (fgDone |-> (coreCalibrating & coreOnline) == 6'h00)
        else $error("calibrating core still online");
    chk_stim_used: assert property (|coreCalibrating |-> stimulusSelect)
        else $error("internal stimulus not selected");
    chk_src_write: assert property (srcWr |=> swapSourceDelay == $past(pwdata[7:0]))
        else $error("source delay write lost");
    chk_src_hold: assert property ($changed(swapSourceDelay) |->
        $past(psel && penable && pwrite && paddr == 12'h268))
        else $error("source delay changed unasked");
    chk_sel_write: assert property (selWr |=> swapSelectDelay == $past(pwdata[7:0]))
        else $error("select delay write lost");
    chk_swap_edge: assert property (fgDone && $past(fgDone) && $changed(coreOnline) |->
        $past(sampleStrobe))
        else $error("core swap off sample boundary");
endmodule // cal_seq_chk
bind adc_core_calibration_sequencer cal_seq_chk u_chk (.mclk(mclk), .arst_n(arst_n),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pready(pready), .pslverr(pslverr), .sampleStrobe(sampleStrobe), .sampleOut(sampleOut),
    .coreOnline(coreOnline), .coreCalibrating(coreCalibrating), .fgDone(fgDone),
    .stimulusSelect(stimulusSelect), .swapSourceDelay(swapSourceDelay),
    .swapSelectDelay(swapSelectDelay));

//--- tb/testbench.sv
`timescale 1ns/1ps
// --------------------------------
// Sequencer testbench
// --------------------------------
module testbench;
    logic mclk = 1'b0;
    logic arst_n = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, trigPin = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, rd;
    wire [31:0] prdata;
    wire pready, pslverr, sampleStrobe, stimulusSelect, offsetCalActive, fgDone;
    wire [35:0] coreSamples, sampleOut;
    wire [5:0] coreOnline, coreCalibrating;
    wire [7:0] swapSourceDelay, swapSelectDelay;
    integer failures = 0, checks = 0, cycles = 0;
    logic [5:0] calSeen;
    logic ofsSeen, outSeen;
    // Clock
    always #10 mclk = ~mclk;
    core_feed u_core_feed (.mclk(mclk), .arst_n(arst_n), .sampleStrobe(sampleStrobe),
        .coreSamples(coreSamples));
    adc_core_calibration_sequencer u_adc_core_calibration_sequencer (.mclk(mclk),
        .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .calibration_trigger_pin(trigPin), .sampleStrobe(sampleStrobe),
        .coreSamples(coreSamples), .sampleOut(sampleOut), .coreOnline(coreOnline),
        .coreCalibrating(coreCalibrating), .stimulusSelect(stimulusSelect),
        .offsetCalActive(offsetCalActive), .fgDone(fgDone),
        .swapSourceDelay(swapSourceDelay), .swapSelectDelay(swapSelectDelay));
    task automatic check(input logic [35:0] seen, input logic [35:0] exp);
        checks = checks + 1;
        if (seen !== exp)
        begin
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
            failures = failures + 1;
        end
    endtask
    // APB transfer, read data kept in rd
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge mclk);
        {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, wr, a, d};
        @(posedge mclk);
        penable <= 1'b1;
        do @(posedge mclk); while (pready !== 1'b1);
        rd = prdata;
        {psel, penable} <= 2'b00;
    endtask
    task automatic wait_done(input logic v);
        for (int i = 0; i < 2000 && fgDone !== v; i++) @(posedge mclk);
    endtask
    // Collect activity over n cycles
    task automatic watch(input int n);
        {calSeen, ofsSeen, outSeen} = 8'h00;
        repeat (n)
        begin
            @(posedge mclk);
            calSeen = calSeen | coreCalibrating;
            ofsSeen = ofsSeen | (offsetCalActive === 1'b1);
            outSeen = outSeen | (sampleOut !== 36'h0);
        end
    endtask
    task wrap_up;
        if (failures == 0 && checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    // Hang guard
    always @(posedge mclk)
    begin
        cycles = cycles + 1;
        if (cycles == 30000)
        begin
            failures = failures + 1;
            wrap_up;
        end
    end
    // Main sequence
    initial
    begin
        repeat (16) @(posedge mclk);
        arst_n <= 1'b1;
        @(posedge mclk);
        #1 check(sampleOut, 36'h0);
        check(fgDone, 1'b0);
        wait_done(1'b1);
        check(fgDone, 1'b1);
        watch(8);
        check(coreOnline, 6'h33);
        apb(1'b0, 12'h010, 0);
        check(rd, 0);
        apb(1'b0, 12'h268, 0);
        check(rd, 0);
        apb(1'b1, 12'h268, 32'h1f);
        apb(1'b1, 12'h26c, 32'h1e);
        apb(1'b0, 12'h268, 0);
        check(rd, 32'h1f);
        apb(1'b0, 12'h26c, 0);
        check(rd, 32'h1e);
        check({swapSourceDelay, swapSelectDelay}, 16'h1f1e);
        apb(1'b0, 12'h100, 0);
        check(rd, 0);
        apb(1'b1, 12'h018, 32'd17);
        apb(1'b0, 12'h01c, 0);
        check(rd, 32'h80);
        apb(1'b1, 12'h01c, 32'h55);
        apb(1'b0, 12'h01c, 0);
        check(rd, 32'h55);
        // Software trigger with foreground offset
        apb(1'b1, 12'h010, 32'h0c);
        wait_done(1'b0);
        check(fgDone, 1'b0);
        watch(300);
        check({ofsSeen, fgDone}, 2'b11);
        check(calSeen !== 6'h00, 1'b1);
        // Pin selected: soft bit ignored, pin edge starts
        apb(1'b1, 12'h010, 32'h06);
        watch(30);
        check(fgDone, 1'b1);
        trigPin <= 1'b1;
        wait_done(1'b0);
        check(fgDone, 1'b0);
        trigPin <= 1'b0;
        watch(300);
        check({ofsSeen, fgDone}, 2'b01);
        // Background, quad then dual then single
        apb(1'b1, 12'h010, 0);
        apb(1'b1, 12'h010, 32'h05);
        watch(3000);
        check({fgDone, outSeen, |calSeen[2:0], |calSeen[5:3]}, 4'hf);
        apb(1'b1, 12'h010, 0);
        watch(300);
        apb(1'b1, 12'h010, 32'h25);
        watch(3000);
        check({calSeen[5:3], |calSeen[2:0]}, 4'h1);
        apb(1'b1, 12'h010, 0);
        watch(300);
        apb(1'b1, 12'h010, 32'h45);
        watch(3000);
        check({calSeen & 6'h3a, |calSeen}, 7'h01);
        wrap_up;
    end
endmodule // testbench
